// ==== include/ptos_pkg.sv ====
`default_nettype none
// ==================================================================
// shared constants and types of the output sequencer
package ptos_pkg;
  // ================================================================
  // sizes
  localparam int unsigned PTOS_OUTS = 4;
  localparam int unsigned PTOS_MAX_SEQ = 125;
  localparam int unsigned PTOS_SEQ_W = 7;
  localparam int unsigned PTOS_IVL_W = 19;
  localparam int unsigned PTOS_RPT_W = 20;
  // ================================================================
  // limits of the programmed values
  localparam logic [18:0] PTOS_IVL_MIN_S = 19'h00001;
  localparam logic [18:0] PTOS_IVL_MAX_S = 19'(99 * 3600 + 59 * 60 + 59);
  localparam logic [19:0] PTOS_RPT_MIN = 20'h00001;
  localparam logic [19:0] PTOS_RPT_MAX = 20'(999999);
  localparam logic [6:0] PTOS_SEQ_MIN = 7'h01;
  localparam logic [6:0] PTOS_SEQ_MAX = 7'(PTOS_MAX_SEQ);
  // ================================================================
  // timing
  localparam int unsigned PTOS_CLK_PERIOD_NS = 10;
  localparam int unsigned PTOS_SECOND_NS = 1000000000;
  localparam int unsigned PTOS_CYC_PER_SEC = PTOS_SECOND_NS / PTOS_CLK_PERIOD_NS;
  // ================================================================
  // register byte offsets
  localparam logic [5:0] PTOS_REG_CTRL = 6'h00;
  localparam logic [5:0] PTOS_REG_SEQCNT = 6'h04;
  localparam logic [5:0] PTOS_REG_REPEAT = 6'h08;
  localparam logic [5:0] PTOS_REG_TABADDR = 6'h0c;
  localparam logic [5:0] PTOS_REG_TABDATA = 6'h10;
  localparam logic [5:0] PTOS_REG_STATUS = 6'h14;
  localparam logic [5:0] PTOS_REG_REMAIN = 6'h18;
  localparam logic [5:0] PTOS_REG_CYCLES = 6'h1c;
  // ================================================================
  // field positions and reset values
  localparam int unsigned PTOS_TAB_COMB_LSB = 0;
  localparam int unsigned PTOS_TAB_IVL_LSB = 4;
  localparam int unsigned PTOS_ST_HELD_BIT = 8;
  localparam int unsigned PTOS_ST_STATE_LSB = 9;
  localparam logic [3:0] PTOS_CTRL_RST = 4'h0;
  localparam logic [6:0] PTOS_SEQCNT_RST = 7'h01;
  localparam logic [19:0] PTOS_RPT_RST = 20'h00001;
  localparam logic [3:0] PTOS_IDLE_COMB = 4'h0;
  // ================================================================
  // types
  typedef enum logic [1:0] {
    PTOS_IDLE = 2'b00,
    PTOS_STEP = 2'b01,
    PTOS_DONE = 2'b10
  } ptos_state_t;
  typedef struct packed {
    logic enable;
    logic loopForever;
    logic autoStart;
    logic timeMode;
  } ptos_ctrl_t;
  typedef struct packed {
    logic [18:0] interval;
    logic [3:0] comb;
  } ptos_entry_t;
endpackage : ptos_pkg
`default_nettype wire

// ==== rtl/ptos_sequencer.sv ====
// What this block does
// - four outputs follow the active entry's combination
// - advance by input pulse or interval expiry
// - reset enters fixed all-open sequence zero
// - pulse mode: each advance pulse steps once
// - pulse mode wraps to zero, or one
// - time mode: pulse launches, intervals then advance
// - time mode end: idle, or one with self-launch
// - pulse mode self-launch jumps to sequence one
// - time mode self-launch starts schedule itself
// - pulse mode hold blocks advance pulses
// - time mode hold freezes countdown and outputs
// - pulse mode resume re-enables advance pulses
// - time mode resume continues frozen countdown
// - pulse mode return aborts to sequence zero
// - time mode return aborts to sequence zero
// - intervals one second to 99:59:59
// - cycle repeats one to 999999, or loop
// - table holds up to 125 entries
// - host writes table and options, device applies
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ptos_sequencer
  import ptos_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = PTOS_CYC_PER_SEC
)(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // control inputs from pins
  input wire logic advanceInput,
  input wire logic holdInput,
  input wire logic resumeInput,
  input wire logic returnInput,
  // relay drives
  output logic [3:0] switchedOutputs
);
  localparam int unsigned PW = (CYC_PER_SEC > 1) ? $clog2(CYC_PER_SEC) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_SEC - 1);

  // ================================================================
  // input synchronisers
  logic [3:0] syncA_q, syncB_q, syncC_q;
  wire [3:0] pinsRaw = {returnInput, resumeInput, holdInput, advanceInput};

  // two stages, then a third for edge detection
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      syncA_q <= 4'h0;
      syncB_q <= 4'h0;
      syncC_q <= 4'h0;
    end
    else
    begin
      syncA_q <= pinsRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  // one-cycle pulse per rising edge
  wire [3:0] edgeSeen = syncB_q & ~syncC_q;
  wire advPulse = edgeSeen[0];
  wire holdPulse = edgeSeen[1];
  wire resumePulse = edgeSeen[2];
  wire retPulse = edgeSeen[3];

  // ================================================================
  // configuration registers and program table
  ptos_ctrl_t ctrl_q;
  logic [6:0] seqCnt_q;
  logic [19:0] rpt_q;
  logic [6:0] tabAddr_q;
  ptos_entry_t tabMem [PTOS_MAX_SEQ];
  logic avWait_q;
  logic [31:0] rdData_q;

  // sequencer state
  ptos_state_t state_q, state_d;
  logic [6:0] seq_q, seq_d;
  logic held_q, held_d;
  logic [19:0] cycles_q, cycles_d;
  logic [18:0] remain_q, remain_d;
  logic [PW-1:0] pre_q, pre_d;
  logic [3:0] out_q, out_d;
  logic load;

  // ================================================================
  // bus decode
  wire avReq = avs_read | avs_write;
  wire avDone = avReq & ~avWait_q;
  wire [5:0] byteAddr = {avs_address, 2'b00};
  wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire selCtrl = byteAddr == PTOS_REG_CTRL;
  wire selSeqCnt = byteAddr == PTOS_REG_SEQCNT;
  wire selRpt = byteAddr == PTOS_REG_REPEAT;
  wire selTabAddr = byteAddr == PTOS_REG_TABADDR;
  wire selTabData = byteAddr == PTOS_REG_TABDATA;
  wire selStatus = byteAddr == PTOS_REG_STATUS;
  wire selRemain = byteAddr == PTOS_REG_REMAIN;
  wire selCycles = byteAddr == PTOS_REG_CYCLES;
  wire mapped = avs_address[3] == 1'b0;

  // readback selection; unmapped reads return zero
  wire ptos_entry_t tabRd = tabMem[tabAddr_q];
  wire [31:0] statusWord = {21'h0, state_q, held_q, 1'b0, seq_q};
  wire [31:0] rdMux =
    !mapped ? 32'h0 :
    selCtrl ? {28'h0, ctrl_q} :
    selSeqCnt ? {25'h0, seqCnt_q} :
    selRpt ? {12'h0, rpt_q} :
    selTabAddr ? {25'h0, tabAddr_q} :
    selTabData ? {9'h0, tabRd} :
    selStatus ? statusWord :
    selRemain ? {13'h0, remain_q} :
    {12'h0, cycles_q};

  // byte-lane merge with the current contents
  wire [31:0] wrVal = (rdMux & ~beMask) | (avs_writedata & beMask);
  wire doWrite = avDone & avs_write & mapped;

  // clamp written counts, repeats and intervals into their legal ranges; out-of-range table addresses are ignored
  wire [6:0] wrSeq = wrVal[6:0];
  wire [6:0] seqClamp = (wrSeq < PTOS_SEQ_MIN) ? PTOS_SEQ_MIN :
                        (wrSeq > PTOS_SEQ_MAX) ? PTOS_SEQ_MAX : wrSeq;
  wire [19:0] wrRpt = wrVal[19:0];
  wire [19:0] rptClamp = (wrRpt < PTOS_RPT_MIN) ? PTOS_RPT_MIN :
                         (wrRpt > PTOS_RPT_MAX) ? PTOS_RPT_MAX : wrRpt;
  wire [18:0] wrIvl = wrVal[PTOS_TAB_IVL_LSB +: PTOS_IVL_W];
  wire [18:0] ivlClamp = (wrIvl < PTOS_IVL_MIN_S) ? PTOS_IVL_MIN_S :
                         (wrIvl > PTOS_IVL_MAX_S) ? PTOS_IVL_MAX_S : wrIvl;
  wire tabAddrOk = wrVal[6:0] < PTOS_SEQ_MAX;

  // one wait cycle per request, answer registered
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      avWait_q <= 1'b1;
      rdData_q <= 32'h0;
    end
    else
    begin
      avWait_q <= ~(avReq & avWait_q);
      if (avReq & avWait_q)
        rdData_q <= rdMux;
    end
  end

  // host-written settings
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_q <= PTOS_CTRL_RST;
      seqCnt_q <= PTOS_SEQCNT_RST;
      rpt_q <= PTOS_RPT_RST;
      tabAddr_q <= 7'h00;
    end
    else if (doWrite)
    begin
      if (selCtrl)
        ctrl_q <= wrVal[3:0];
      if (selSeqCnt)
        seqCnt_q <= seqClamp;
      if (selRpt)
        rpt_q <= rptClamp;
      if (selTabAddr && tabAddrOk)
        tabAddr_q <= wrVal[6:0];
    end
  end

  // program table, one entry per sequence one and up
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < PTOS_MAX_SEQ; i++)
        tabMem[i] <= '{interval: PTOS_IVL_MIN_S, comb: PTOS_IDLE_COMB};
    end
    else if (doWrite && selTabData)
    begin
      tabMem[tabAddr_q] <= '{interval: ivlClamp, comb: wrVal[3:0]};
    end
  end

  // ================================================================
  // sequencer decode
  wire running = state_q == PTOS_STEP;
  wire counting = running & ctrl_q.timeMode & ~held_q;
  wire secTick = counting & (pre_q == PRE_LAST);
  wire expire = secTick & (remain_q <= PTOS_IVL_MIN_S);
  wire pulseStep = ~ctrl_q.timeMode & advPulse & ~held_q;
  wire stepOn = running & (ctrl_q.timeMode ? expire : pulseStep);
  wire atLast = seq_q >= seqCnt_q;
  wire [19:0] cyclesInc = cycles_q + 20'h00001;
  wire finished = ~ctrl_q.loopForever & (cyclesInc >= rpt_q);
  wire launch = (state_q == PTOS_IDLE) & ~held_q &
                (advPulse | ctrl_q.autoStart);

  // next sequence, hold and repeat count
  always_comb
  begin
    state_d = state_q;
    seq_d = seq_q;
    held_d = held_q;
    cycles_d = cycles_q;
    load = 1'b0;
    if (!ctrl_q.enable || retPulse)
    begin
      state_d = PTOS_IDLE;
      seq_d = 7'h00;
      held_d = 1'b0;
      cycles_d = 20'h0;
    end
    else
    begin
      if (holdPulse)
        held_d = 1'b1;
      else if (resumePulse)
        held_d = 1'b0;
      case (state_q)
        PTOS_IDLE:
        begin
          if (launch)
          begin
            state_d = PTOS_STEP;
            seq_d = 7'h01;
            load = 1'b1;
          end
        end
        PTOS_STEP:
        begin
          if (stepOn && atLast)
          begin
            cycles_d = cyclesInc;
            if (finished)
            begin
              state_d = PTOS_DONE;
              seq_d = 7'h00;
            end
            else if (ctrl_q.autoStart)
            begin
              seq_d = 7'h01;
              load = 1'b1;
            end
            else
            begin
              state_d = PTOS_IDLE;
              seq_d = 7'h00;
            end
          end
          else if (stepOn)
          begin
            seq_d = seq_q + 7'h01;
            load = 1'b1;
          end
        end
        PTOS_DONE:
        begin
          seq_d = 7'h00;
        end
        default:
        begin
          state_d = PTOS_IDLE;
          seq_d = 7'h00;
        end
      endcase
    end
  end

  // entry fetched for the sequence being entered
  wire [6:0] nextIdx = seq_d - 7'h01;
  wire ptos_entry_t nextEntry = tabMem[nextIdx];

  // outputs and countdown follow the entered entry
  always_comb
  begin
    out_d = out_q;
    remain_d = remain_q;
    pre_d = pre_q;
    if (seq_d == 7'h00)
    begin
      out_d = PTOS_IDLE_COMB;
      remain_d = 19'h0;
      pre_d = '0;
    end
    else if (load)
    begin
      out_d = nextEntry.comb;
      remain_d = nextEntry.interval;
      pre_d = '0;
    end
    else if (secTick)
    begin
      remain_d = remain_q - 19'h00001;
      pre_d = '0;
    end
    else if (counting)
      pre_d = pre_q + PW'(1);
  end

  // sequencer registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= PTOS_IDLE;
      seq_q <= 7'h00;
      held_q <= 1'b0;
      cycles_q <= 20'h0;
      remain_q <= 19'h0;
      pre_q <= '0;
      out_q <= PTOS_IDLE_COMB;
    end
    else
    begin
      state_q <= state_d;
      seq_q <= seq_d;
      held_q <= held_d;
      cycles_q <= cycles_d;
      remain_q <= remain_d;
      pre_q <= pre_d;
      out_q <= out_d;
    end
  end

  // ================================================================
  // outputs
  assign avs_readdata = rdData_q;
  assign avs_waitrequest = avWait_q;
  assign switchedOutputs = out_q;

  // ================================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  idle_outputs_open_a: assert property (seq_q == 7'h00 |-> switchedOutputs == 4'h0)
    else $error("outputs not open in sequence zero");
  reset_enters_idle_a: assert property (disable iff (1'b0) rst |=> seq_q == 7'h00)
    else $error("reset did not enter sequence zero");
  pulse_step_once_a: assert property (running && !ctrl_q.timeMode && advPulse && !held_q
    && !atLast && !retPulse && ctrl_q.enable |=> seq_q == $past(seq_q) + 7'h01)
    else $error("pulse did not step exactly once");
  launch_seq_one_a: assert property (state_q == PTOS_IDLE && ctrl_q.enable && advPulse
    && !held_q && !retPulse |=> seq_q == 7'h01 && state_q == PTOS_STEP)
    else $error("launch did not reach sequence one");
  return_wins_a: assert property (retPulse |=> seq_q == 7'h00 && !held_q
    && state_q == PTOS_IDLE)
    else $error("return did not abort to idle");
  hold_blocks_pulse_a: assert property (held_q && !ctrl_q.timeMode && running
    && !retPulse && ctrl_q.enable |=> seq_q == $past(seq_q))
    else $error("held pulse mode still advanced");
  hold_freezes_count_a: assert property (held_q && ctrl_q.timeMode && running
    && !retPulse && ctrl_q.enable |=> $stable(remain_q) && $stable(pre_q)
    && $stable(switchedOutputs))
    else $error("countdown moved while held");
  second_countdown_a: assert property (secTick && remain_q > 19'h00001 && !retPulse
    && ctrl_q.enable |=> remain_q == $past(remain_q) - 19'h00001)
    else $error("countdown did not drop by one second");
  autostart_wrap_a: assert property (stepOn && atLast && !finished && ctrl_q.autoStart
    && !retPulse && ctrl_q.enable |=> seq_q == 7'h01)
    else $error("self-launch did not wrap to sequence one");
  repeat_done_a: assert property (stepOn && atLast && finished && !retPulse
    && ctrl_q.enable |=> state_q == PTOS_DONE ##1 (state_q == PTOS_DONE
    || $past(retPulse) || !$past(ctrl_q.enable)))
    else $error("repeat limit did not stop the cycle");
  single_action_a: assert property (advPulse |=> !advPulse)
    else $error("one input edge acted twice");
  bus_wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than a cycle");

  launch_c: cover property (state_q == PTOS_IDLE ##1 state_q == PTOS_STEP);
  expire_step_c: cover property (expire && !atLast ##1 running);
  hold_return_c: cover property (held_q && retPulse);
  finished_c: cover property (state_q == PTOS_DONE);
endmodule : ptos_sequencer
`default_nettype wire

// ==== tb/ptos_switch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// switch bank driving the four control pins
module ptos_switch_model (
  // clock
  input wire logic clock,
  // pins to the sequencer, released pins fall back to the pull-down level
  output logic [3:0] pins
);
  initial pins = 4'h0;
  // one clean pulse: three cycles closed, two cycles open
  task automatic press(input logic [3:0] which);
    @(posedge clock);
    pins <= which;
    repeat (3) @(posedge clock);
    pins <= 4'h0;
    repeat (2) @(posedge clock);
  endtask : press
endmodule : ptos_switch_model
`default_nettype wire

// ==== tb/ptos_sequencer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// self-checking bench of the output sequencer
module ptos_sequencer_test
  import ptos_pkg::*;
;
  localparam int unsigned CPS = 10;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] pins;
  logic [3:0] switchedOutputs;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int c;
  logic [3:0] comb [3];
  logic [18:0] ivl [3];
  logic [31:0] rd;
  logic [31:0] r1;
  // ==================================================
  // design and switch bank
  ptos_sequencer #(.CYC_PER_SEC(CPS)) u_dut (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .advanceInput(pins[0]), .holdInput(pins[1]),
    .resumeInput(pins[2]), .returnInput(pins[3]), .switchedOutputs(switchedOutputs));
  ptos_switch_model u_sw (.clock(clock), .pins(pins));
  // clock and hang limit
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end
  // ==================================================
  // helpers
  task automatic end_sim();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] off, input logic [31:0] wd);
    @(posedge clock);
    avs_address <= off[5:2];
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic st(input logic [31:0] e);
    bus(1'b0, PTOS_REG_STATUS, 32'h0);
    chk("status", e, rd);
  endtask : st
  task automatic oc(input logic [3:0] e);
    chk("outs", {28'h0, e}, {28'h0, switchedOutputs});
  endtask : oc
  // pulse a pin and let the outputs settle
  task automatic act(input logic [3:0] w);
    u_sw.press(w);
    @(negedge clock);
  endtask : act
  // count edges until the outputs show a value
  task automatic tw(input logic [3:0] e);
    c = 0;
    while (switchedOutputs !== e && c < 200)
    begin
      @(posedge clock);
      c++;
    end
    // a wait that runs out is a mismatch, not a silent pass
    if (c >= 200)
      chk("reach", {28'h0, e}, {28'h0, switchedOutputs});
  endtask : tw
  function automatic logic [31:0] stx(input logic [1:0] s, input logic h, input int q);
    return {21'h0, s, h, 1'b0, 7'(q)};
  endfunction : stx
  function automatic logic [3:0] ec(input int s);
    return (s == 0) ? PTOS_IDLE_COMB : comb[s - 1];
  endfunction : ec
  // ==================================================
  // main sequence
  initial
  begin
    n = $urandom(32'hbba0);
    for (int i = 0; i < 3; i++)
      comb[i] = 4'(($urandom_range(3, 0) << 2) | (i + 1));
    ivl[0] = 19'h00001;
    ivl[1] = 19'h00003;
    ivl[2] = 19'($urandom_range(4, 1));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    // reset values, unmapped and read-only places
    bus(1'b0, PTOS_REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    bus(1'b0, PTOS_REG_SEQCNT, 32'h0);
    chk("seqcnt", 32'h1, rd);
    bus(1'b0, PTOS_REG_REPEAT, 32'h0);
    chk("repeat", 32'h1, rd);
    bus(1'b0, 6'h24, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, PTOS_REG_STATUS, 32'h7ff);
    st(stx(PTOS_IDLE, 1'b0, 0));
    oc(PTOS_IDLE_COMB);
    // table load, interval clamps at both ends
    bus(1'b1, PTOS_REG_SEQCNT, 32'h3);
    // a disabled byte lane keeps the stored value
    avs_byteenable <= 4'he;
    bus(1'b1, PTOS_REG_SEQCNT, 32'h0);
    avs_byteenable <= 4'hf;
    bus(1'b0, PTOS_REG_SEQCNT, 32'h0);
    chk("lane_keep", 32'h3, rd);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, PTOS_REG_TABADDR, i);
      bus(1'b1, PTOS_REG_TABDATA, {9'h0, (i == 0) ? 19'h0 : ivl[i], comb[i]});
    end
    bus(1'b1, PTOS_REG_TABADDR, 32'h0);
    bus(1'b0, PTOS_REG_TABDATA, 32'h0);
    chk("ivl_min", {9'h0, PTOS_IVL_MIN_S, comb[0]}, rd);
    bus(1'b1, PTOS_REG_TABADDR, 32'h3);
    bus(1'b1, PTOS_REG_TABDATA, 32'h7ffff0);
    bus(1'b0, PTOS_REG_TABDATA, 32'h0);
    chk("ivl_max", {9'h0, PTOS_IVL_MAX_S, 4'h0}, rd);
    // pulse mode, looping
    bus(1'b1, PTOS_REG_CTRL, 32'hc);
    for (int s = 1; s <= 4; s++)
    begin
      act(4'h1);
      oc(ec(s % 4));
    end
    act(4'h2);
    act(4'h1);
    st(stx(PTOS_IDLE, 1'b1, 0));
    act(4'h4);
    act(4'h1);
    oc(ec(1));
    // hold while stepping blocks the advance pulse
    act(4'h2);
    act(4'h1);
    st(stx(PTOS_STEP, 1'b1, 1));
    act(4'h4);
    act(4'h1);
    oc(ec(2));
    act(4'h1);
    act(4'h8);
    st(stx(PTOS_IDLE, 1'b0, 0));
    act(4'h2);
    act(4'ha);
    st(stx(PTOS_IDLE, 1'b0, 0));
    act(4'h1);
    oc(ec(1));
    act(4'h8);
    // single cycle then done
    bus(1'b1, PTOS_REG_CTRL, 32'h8);
    repeat (5) act(4'h1);
    bus(1'b0, PTOS_REG_STATUS, 32'h0);
    chk("done", 32'h2, {30'h0, rd[10:9]});
    bus(1'b0, PTOS_REG_CYCLES, 32'h0);
    chk("cycles", 32'h1, rd);
    oc(PTOS_IDLE_COMB);
    act(4'h8);
    // pulse mode self-launch
    bus(1'b1, PTOS_REG_CTRL, 32'h0);
    bus(1'b1, PTOS_REG_CTRL, 32'he);
    tw(ec(1));
    oc(ec(1));
    repeat (3) act(4'h1);
    oc(ec(1));
    act(4'h1);
    act(4'h8);
    oc(ec(1));
    // time mode
    bus(1'b1, PTOS_REG_CTRL, 32'h0);
    bus(1'b1, PTOS_REG_CTRL, 32'hd);
    oc(PTOS_IDLE_COMB);
    act(4'h1);
    tw(ec(2));
    tw(ec(3));
    chk("step2_len", ivl[1] * CPS, c);
    tw(PTOS_IDLE_COMB);
    chk("step3_len", ivl[2] * CPS, c);
    repeat (5 * CPS) @(posedge clock);
    oc(PTOS_IDLE_COMB);
    // hold freezes, resume carries on
    act(4'h1);
    tw(ec(2));
    act(4'h2);
    bus(1'b0, PTOS_REG_REMAIN, 32'h0);
    r1 = rd;
    repeat (4 * CPS) @(posedge clock);
    bus(1'b0, PTOS_REG_REMAIN, 32'h0);
    chk("frozen", r1, rd);
    oc(ec(2));
    act(4'h4);
    tw(ec(3));
    chk("resumed", 32'h1, {31'h0, c <= int'(r1) * CPS + 8});
    act(4'h8);
    st(stx(PTOS_IDLE, 1'b0, 0));
    // time mode self-launch
    bus(1'b1, PTOS_REG_CTRL, 32'h0);
    bus(1'b1, PTOS_REG_CTRL, 32'hf);
    tw(ec(1));
    chk("auto_start", 32'h1, {31'h0, c <= 8});
    tw(ec(3));
    tw(ec(1));
    oc(ec(1));
    end_sim();
  end
endmodule : ptos_sequencer_test
`default_nettype wire
